// [dv/ibc_cpu_model.sv]
// Behavioural CPU that issues one memory access on the bus for each go pulse seen while no access is active.
`timescale 1ns/1ps
module ibc_cpu_model (
    // Clock.
    input  wire logic        ref_clk,
    // Request from the bench.
    input  wire logic        go,
    input  wire logic        we,
    input  wire logic [16:0] addr,
    input  wire logic [15:0] wdata,
    // Memory bus.
    output logic             op_begin_strobe,
    output logic             write_request,
    output logic [16:0]      inbound_addr_data_bus,
    input  wire logic        busy_reject,
    // Status to the bench.
    output logic             active,
    output logic             rejected
);
    initial begin
        op_begin_strobe       = 1'b0;
        write_request         = 1'b0;
        inbound_addr_data_bus = 17'h00000;
        active                = 1'b0;
        rejected              = 1'b0;
    end

    // Address first, then the write word, then a released bus that shows the inverse.
    always @(posedge ref_clk) begin
        if (go === 1'b1 && !active) begin
            active = 1'b1;
            rejected = 1'b0;
            @(negedge ref_clk);
            op_begin_strobe = 1'b1;
            write_request = we;
            inbound_addr_data_bus = addr;
            for (int i = 0; i < 16; i++) begin
                @(posedge ref_clk);
                @(negedge ref_clk);
                if (busy_reject === 1'b1) begin
                    rejected = 1'b1;
                end
                if (i == 3) begin
                    inbound_addr_data_bus = {1'b0, wdata};
                end
                if (i == 5) begin
                    op_begin_strobe = 1'b0;
                end
            end
            inbound_addr_data_bus = ~inbound_addr_data_bus;
            write_request = 1'b0;
            active = 1'b0;
        end
    end
endmodule

// [dv/test_ibc_ctrl.sv]
// Self-checking bench of the interleaved memory board controller.
`timescale 1ns/1ps
`include "ibc_defs.svh"
module test_ibc_ctrl;
    logic             ref_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             go = 1'b0;
    logic             we = 1'b0;
    logic [16:0]      addr = 17'h00000;
    logic [15:0]      wdata = 16'h0000;
    logic             strobe;
    logic             wr;
    logic [16:0]      bus;
    logic             busy_reject;
    logic [15:0]      outbound_read_bus;
    logic             read_data_valid;
    logic [2:0]       board_jumper = 3'h0;
    logic             battery_fitted = 1'b0;
    logic             supply_good = 1'b1;
    logic [3:0]       rae;
    logic [3:0]       cae;
    logic [3:0]       mws;
    logic [3:0]       bank_select;
    logic [3:0][6:0]  ram_addr;
    logic [15:0]      latched_write_data;
    logic [3:0][15:0] rd_word = '0;
    logic             active;
    logic             rejected;
    int               failures = 0;
    int               total_checks = 0;
    int               cycles = 0;
    int               n;
    time              t0;
    logic [6:0]       r0;
    logic [16:0]      a;

    always #5 ref_clk = ~ref_clk;

    ibc_ctrl #(.BOARD_SIZE(`IBC_SZ_64K)) u_ibc_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .op_begin_strobe(strobe), .write_request(wr),
        .inbound_addr_data_bus(bus), .busy_reject(busy_reject), .outbound_read_bus(outbound_read_bus),
        .read_data_valid(read_data_valid), .board_jumper(board_jumper), .battery_fitted(battery_fitted),
        .supply_good(supply_good), .row_addr_enable(rae), .col_addr_enable(cae), .module_write_strobe(mws),
        .bank_select(bank_select), .ram_addr(ram_addr), .latched_write_data(latched_write_data),
        .module_read_data(rd_word));

    ibc_cpu_model u_ibc_cpu_model (
        .ref_clk(ref_clk), .go(go), .we(we), .addr(addr), .wdata(wdata), .op_begin_strobe(strobe),
        .write_request(wr), .inbound_addr_data_bus(bus), .busy_reject(busy_reject), .active(active),
        .rejected(rejected));

    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic kick(input logic w, input logic [16:0] ad, input logic [15:0] d);
        @(negedge ref_clk);
        we = w;
        addr = ad;
        wdata = d;
        rd_word = {$urandom, $urandom};
        go = 1'b1;
        @(negedge ref_clk);
        go = 1'b0;
    endtask

    task automatic idle_wait(input int c);
        repeat (c) @(negedge ref_clk);
    endtask

    // One access with checks of the row and column phases, write strobe and read data.
    task automatic run_op(input logic w, input logic [16:0] ad, input logic [15:0] d, input logic hit);
        int         t;
        int         wc;
        int         oc;
        logic       seen;
        logic [15:0] got;
        logic [1:0] m;
        m = ad[1:0];
        t = 0;
        wc = 0;
        oc = 0;
        seen = 1'b0;
        got = 16'h0000;
        kick(w, ad, d);
        if (!hit) begin
            repeat (50) begin
                @(negedge ref_clk);
                oc += (rae[m] === 1'b1 || read_data_valid === 1'b1 || busy_reject === 1'b1);
            end
            chk(oc == 0, "access taken that should be ignored");
            return;
        end
        while (rae[m] !== 1'b1 && t < 12) begin
            @(negedge ref_clk);
            t++;
        end
        chk(t < 12 && ram_addr[m] === {1'b0, ad[13:8]} && cae[m] === 1'b0, "row phase");
        chk(bank_select[m] === ad[14], "bank select");
        t = 0;
        while (cae[m] !== 1'b1 && t < 15) begin
            @(negedge ref_clk);
            t++;
        end
        chk(t < 15 && rae[m] === 1'b0 && ram_addr[m] === {1'b0, ad[7:2]}, "column phase");
        repeat (30) begin
            @(negedge ref_clk);
            wc += (mws[m] === 1'b1);
            oc += ((mws & ~(4'h1 << m)) !== 4'h0);
            if (read_data_valid === 1'b1) begin
                seen = 1'b1;
                got = outbound_read_bus;
            end
        end
        if (w) begin
            chk(wc == 10 && oc == 0 && latched_write_data === d && !seen, "write strobe or data");
        end else begin
            chk(seen && got === rd_word[m] && wc == 0, "read data");
        end
        idle_wait(10);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(32'hf60ad63d));
        board_jumper = {1'b0, 2'($urandom_range(3))};
        idle_wait(20);
        rst_n = 1'b1;
        idle_wait(5);
        run_op(1'b1, {board_jumper[1:0], 1'b1, 6'h3F, 6'h3F, 2'h3}, 16'hFFFF, 1'b1);
        repeat (8) begin
            run_op(1'($urandom), {board_jumper[1:0], 15'($urandom)}, 16'($urandom), 1'b1);
        end
        run_op(1'b0, {board_jumper[1:0] + 2'h1, 15'($urandom)}, 16'h0000, 1'b0);
        a = {board_jumper[1:0], 15'($urandom)};
        kick(1'b0, a, 16'h0000);
        while (active) @(negedge ref_clk);
        kick(1'b0, a, 16'h0000);
        while (active) @(negedge ref_clk);
        chk(rejected === 1'b1, "same module not refused");
        idle_wait(60);
        kick(1'b0, a, 16'h0000);
        while (active) @(negedge ref_clk);
        kick(1'b0, a ^ 17'h00001, 16'h0000);
        while (active) @(negedge ref_clk);
        chk(rejected === 1'b0 && cae[a[1:0]] === 1'b1 && cae[a[1:0] ^ 2'h1] === 1'b1, "other module refused");
        n = 0;
        while (rae !== 4'hF && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n < 3000 && ram_addr[0] === ram_addr[3], "refresh missing");
        r0 = ram_addr[0];
        t0 = $time;
        kick(1'b0, a, 16'h0000);
        while (active) @(negedge ref_clk);
        chk(rejected === 1'b1, "select during refresh not refused");
        n = 0;
        while (rae === 4'hF) begin
            @(negedge ref_clk);
            n++;
        end
        while (rae !== 4'hF && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        n = int'(($time - t0) / `IBC_CLK_NS);
        chk(n >= `IBC_REF_SMALL && n <= `IBC_REF_SMALL + 41, "refresh interval");
        chk(ram_addr[0] === r0 + 7'h01, "refresh row not advanced");
        while (rae === 4'hF) @(negedge ref_clk);
        battery_fitted = 1'b1;
        supply_good = 1'b0;
        idle_wait(5);
        run_op(1'b0, a, 16'h0000, 1'b0);
        n = 0;
        while (rae !== 4'hF && n < 2700) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n < 2700, "no refresh on battery");
        stop_test();
    end
endmodule

// [src/ibc_ctrl.sv]
// Control logic of a four-module interleaved dynamic RAM board.
`timescale 1ns/1ps
`include "ibc_defs.svh"
module ibc_ctrl #(
    parameter logic [1:0] BOARD_SIZE = `IBC_SZ_256K
) (
    // Clock and reset.
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    // CPU memory bus.
    input  wire logic            op_begin_strobe,
    input  wire logic            write_request,
    input  wire logic [16:0]     inbound_addr_data_bus,
    output logic                 busy_reject,
    output logic [15:0]          outbound_read_bus,
    output logic                 read_data_valid,
    // Board straps and power.
    input  wire logic [2:0]      board_jumper,
    input  wire logic            battery_fitted,
    input  wire logic            supply_good,
    // RAM array.
    output logic [3:0]           row_addr_enable,
    output logic [3:0]           col_addr_enable,
    output logic [3:0]           module_write_strobe,
    output logic [3:0]           bank_select,
    output logic [3:0][6:0]      ram_addr,
    output logic [15:0]          latched_write_data,
    input  wire logic [3:0][15:0] module_read_data
);
    localparam int MOD_CYC  = `IBC_MOD_CYC;
    localparam int MOD_LAST = MOD_CYC - 1;
    localparam int REF_LEN  = `IBC_REF_LEN;
    localparam int SW       = 88;

    logic [1:0]           rst_sync_q;
    logic                 rst_ok;
    logic [SW-1:0]        s1_q;
    logic [SW-1:0]        s2_q;
    logic                 strb_s;
    logic                 wreq_s;
    logic                 sgood_s;
    logic                 batt_s;
    logic [2:0]           jump_s;
    logic [16:0]          bus_s;
    logic [3:0][15:0]     rd_s;
    logic                 strb_prev_q;
    logic                 strb_rise;
    logic                 pfail;
    ibc_pkg::ibc_if_e     state_q;
    logic [16:0]          addr_q;
    ibc_pkg::ibc_req_s    req;
    logic [5:0]           dcnt_q;
    logic                 conflict;
    logic                 launch;
    logic [1:0]           ptr_q;
    logic [3:0]           busy_q;
    logic [3:0]           wr_q;
    logic [3:0][5:0]      cnt_q;
    logic [3:0][6:0]      row_q;
    logic [3:0][6:0]      col_q;
    logic [3:0][1:0]      optr_q;
    logic [3:0]           rd_done;
    logic [1:0]           rd_idx;
    logic [15:0]          muxed_read_data;
    logic [3:0][15:0]     held_read_data;
    logic [11:0]          tmr_q;
    logic                 ref_tick;
    logic                 ref_pend_q;
    logic                 ref_act_q;
    logic [5:0]           ref_cnt_q;
    logic [6:0]           ref_row_q;
    logic                 ref_start;
    logic                 ref_end;

    // Decodes a captured address into module, bank, row, column and board hit.
    function automatic ibc_pkg::ibc_req_s decode(input logic [16:0] a, input logic [2:0] j);
        ibc_pkg::ibc_req_s r;
        int                cap;
        logic [16:0]       hi;
        r     = '0;
        cap   = (BOARD_SIZE == `IBC_SZ_256K) ? `IBC_CAP_256K :
                (BOARD_SIZE == `IBC_SZ_128K) ? `IBC_CAP_128K :
                (BOARD_SIZE == `IBC_SZ_64K)  ? `IBC_CAP_64K  : `IBC_CAP_32K;
        hi    = a >> cap;
        r.hit = (BOARD_SIZE == `IBC_SZ_256K) || (hi == {14'h0000, j});
        r.mod = a[1:0];
        if (BOARD_SIZE[1]) begin
            r.col = a[8:2];
            r.row = a[15:9];
        end else begin
            r.col = {1'b0, a[7:2]};
            r.row = {1'b0, a[13:8]};
        end
        r.bank = (BOARD_SIZE == `IBC_SZ_256K) ? a[16] :
                 (BOARD_SIZE == `IBC_SZ_64K)  ? a[14] : 1'b0;
        return r;
    endfunction

    // Picks the lowest module finishing a read this cycle.
    function automatic logic [1:0] first_set(input logic [3:0] v);
        logic [1:0] k;
        k = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                k = 2'(i);
            end
        end
        return k;
    endfunction

    // Reset release and input synchronisers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_ok = rst_sync_q[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {op_begin_strobe, write_request, supply_good, battery_fitted,
                     board_jumper, inbound_addr_data_bus, module_read_data};
            s2_q <= s1_q;
        end
    end
    assign {strb_s, wreq_s, sgood_s, batt_s, jump_s, bus_s, rd_s} = s2_q;
    assign pfail     = batt_s & ~sgood_s;
    assign strb_rise = strb_s & ~strb_prev_q;

    // Shared interface sequencer.
    assign req      = decode(addr_q, jump_s);
    assign conflict = busy_q[req.mod] | ref_act_q;
    assign launch   = (state_q == ibc_pkg::IF_SEL) && req.hit && !conflict;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= ibc_pkg::IF_IDLE;
            strb_prev_q <= 1'b0;
            addr_q      <= '0;
            dcnt_q      <= '0;
        end else if (!rst_ok) begin
            state_q     <= ibc_pkg::IF_IDLE;
            strb_prev_q <= 1'b0;
        end else begin
            strb_prev_q <= strb_s;
            unique case (state_q)
                ibc_pkg::IF_IDLE: begin
                    if (strb_rise && !pfail) begin
                        addr_q  <= bus_s;
                        state_q <= ibc_pkg::IF_SEL;
                    end
                end
                ibc_pkg::IF_SEL: begin
                    dcnt_q  <= '0;
                    state_q <= (launch && wreq_s) ? ibc_pkg::IF_DATA : ibc_pkg::IF_IDLE;
                end
                ibc_pkg::IF_DATA: begin
                    dcnt_q <= dcnt_q + 6'h01;
                    if (dcnt_q == 6'(`IBC_DATA_CYC - 1)) begin
                        state_q <= ibc_pkg::IF_IDLE;
                    end
                end
            endcase
        end
    end

    // Write data latch.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_write_data <= '0;
        end else if (state_q == ibc_pkg::IF_DATA && dcnt_q == 6'(`IBC_DATA_CYC - 1)) begin
            latched_write_data <= bus_s[15:0];
        end
    end

    // Busy reject: set on a conflicting select, held until the strobe drops.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reject <= 1'b0;
        end else if (state_q == ibc_pkg::IF_SEL && req.hit && conflict) begin
            busy_reject <= 1'b1;
        end else if (!strb_s) begin
            busy_reject <= 1'b0;
        end
    end

    // Output register pointer.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= 2'h0;
        end else if (!rst_ok) begin
            ptr_q <= 2'h0;
        end else if (launch) begin
            ptr_q <= ptr_q + 2'h1;
        end
    end

    // Per-module timing generators and address latches.
    for (genvar m = 0; m < 4; m++) begin : g_mod
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                busy_q[m]         <= 1'b0;
                cnt_q[m]          <= '0;
                wr_q[m]           <= 1'b0;
                row_q[m]          <= '0;
                col_q[m]          <= '0;
                bank_select[m]    <= 1'b0;
                optr_q[m]         <= 2'h0;
            end else if (!rst_ok) begin
                busy_q[m] <= 1'b0;
            end else if (launch && req.mod == 2'(m)) begin
                busy_q[m]      <= 1'b1;
                cnt_q[m]       <= '0;
                wr_q[m]        <= wreq_s;
                row_q[m]       <= req.row;
                col_q[m]       <= req.col;
                bank_select[m] <= req.bank;
                optr_q[m]      <= ptr_q;
            end else if (busy_q[m]) begin
                cnt_q[m] <= cnt_q[m] + 6'h01;
                if (cnt_q[m] == 6'(MOD_LAST)) begin
                    busy_q[m] <= 1'b0;
                end
            end
        end

        assign row_addr_enable[m] = ref_act_q
                                  | (busy_q[m] & (cnt_q[m] < 6'(`IBC_ROW_CYC)));
        assign col_addr_enable[m] = ~ref_act_q & busy_q[m]
                                  & (cnt_q[m] >= 6'(`IBC_ROW_CYC));
        assign module_write_strobe[m] = busy_q[m] & wr_q[m]
                                      & (cnt_q[m] >= 6'(`IBC_WE_BEG_CYC))
                                      & (cnt_q[m] < 6'(`IBC_WE_END_CYC));
        assign ram_addr[m] = ref_act_q ? ref_row_q :
                             (cnt_q[m] < 6'(`IBC_ROW_CYC)) ? row_q[m] : col_q[m];
        assign rd_done[m] = busy_q[m] & ~wr_q[m] & (cnt_q[m] == 6'(`IBC_RD_CYC - 1));

        a_row_then_col: assert property (@(posedge ref_clk) disable iff (!rst_ok)
            $rose(busy_q[m]) |-> row_addr_enable[m] && !col_addr_enable[m]
            ##(`IBC_ROW_CYC) col_addr_enable[m]) else $error("column phase out of order");
        a_mod_cycle_len: assert property (@(posedge ref_clk) disable iff (!rst_ok)
            $rose(busy_q[m]) |-> ##MOD_LAST busy_q[m] ##1 !busy_q[m])
            else $error("module cycle length wrong");
        a_we_col_only: assert property (@(posedge ref_clk) disable iff (!rst_ok)
            module_write_strobe[m] |-> col_addr_enable[m] && wr_q[m] && $stable(col_q[m]))
            else $error("write strobe outside column phase");
    end

    // Four-to-one read mux and rotating output registers.
    assign rd_idx          = first_set(rd_done);
    assign muxed_read_data = rd_s[rd_idx];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_read_data    <= '0;
            outbound_read_bus <= '0;
            read_data_valid   <= 1'b0;
        end else begin
            read_data_valid <= |rd_done;
            if (|rd_done) begin
                held_read_data[optr_q[rd_idx]] <= muxed_read_data;
                outbound_read_bus              <= muxed_read_data;
            end
        end
    end

    // Refresh interval timer and sequencer.
    assign ref_tick  = tmr_q == 12'(BOARD_SIZE[1] ? `IBC_REF_LARGE - 1 : `IBC_REF_SMALL - 1);
    assign ref_start = ref_pend_q && !ref_act_q && busy_q == 4'h0
                     && state_q == ibc_pkg::IF_IDLE;
    assign ref_end   = ref_act_q && ref_cnt_q == 6'(REF_LEN - 1);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= ref_tick ? 12'h000 : tmr_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_pend_q <= 1'b0;
        end else if (ref_tick) begin
            ref_pend_q <= 1'b1;
        end else if (ref_start) begin
            ref_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_act_q <= 1'b0;
            ref_cnt_q <= '0;
            ref_row_q <= '0;
        end else if (ref_start) begin
            ref_act_q <= 1'b1;
            ref_cnt_q <= '0;
        end else if (ref_end) begin
            ref_act_q <= 1'b0;
            ref_row_q <= ref_row_q + 7'h01;
        end else if (ref_act_q) begin
            ref_cnt_q <= ref_cnt_q + 6'h01;
        end
    end

    sequence s_sel_conflict;
        state_q == ibc_pkg::IF_SEL && req.hit && conflict;
    endsequence
    sequence s_pfail_idle;
        pfail && state_q == ibc_pkg::IF_IDLE;
    endsequence

    a_reject_busy: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        s_sel_conflict |=> busy_reject && (busy_q & ~$past(busy_q)) == 4'h0 && ptr_q == $past(ptr_q))
        else $error("conflict not rejected");
    a_nohit_quiet: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        state_q == ibc_pkg::IF_SEL && !req.hit |-> !launch ##1 state_q == ibc_pkg::IF_IDLE)
        else $error("foreign address accepted");
    a_ptr_rotate: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        launch |=> ptr_q == $past(ptr_q) + 2'h1) else $error("pointer did not advance");
    a_pfail_quiet: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        s_pfail_idle |=> state_q == ibc_pkg::IF_IDLE) else $error("access during power fail");
    a_ref_idle: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        $rose(ref_act_q) |-> $past(busy_q) == 4'h0 ##1 row_addr_enable == 4'hF)
        else $error("refresh overlapped module cycle");
    a_read_load: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        |rd_done |=> read_data_valid && outbound_read_bus == $past(muxed_read_data)
        && held_read_data[$past(optr_q[rd_idx])] == $past(muxed_read_data))
        else $error("read data not loaded");
    a_wdata_latch: assert property (@(posedge ref_clk) disable iff (!rst_ok)
        state_q == ibc_pkg::IF_SEL && launch && wreq_s |-> ##(`IBC_DATA_CYC + 1)
        latched_write_data == $past(bus_s[15:0])) else $error("write data not captured");
endmodule

// [src/ibc_defs.svh]
// Timing, sizing and field constants of the interleaved memory board controller.
`ifndef IBC_DEFS_SVH
`define IBC_DEFS_SVH
`define IBC_CLK_NS       10
`define IBC_CYC_NS       400
`define IBC_ROW_NS       100
`define IBC_DATA_NS      100
`define IBC_WE_BEG_NS    200
`define IBC_WE_END_NS    300
`define IBC_RD_NS        300
`define IBC_REF_SMALL_NS 25000
`define IBC_REF_LARGE_NS 13000
`define IBC_REF_LEN_NS   400
`define IBC_MOD_CYC      (`IBC_CYC_NS / `IBC_CLK_NS)
`define IBC_ROW_CYC      ((`IBC_ROW_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_DATA_CYC     ((`IBC_DATA_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_WE_BEG_CYC   ((`IBC_WE_BEG_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_WE_END_CYC   (`IBC_WE_END_NS / `IBC_CLK_NS)
`define IBC_RD_CYC       (`IBC_RD_NS / `IBC_CLK_NS)
`define IBC_REF_SMALL    (`IBC_REF_SMALL_NS / `IBC_CLK_NS)
`define IBC_REF_LARGE    (`IBC_REF_LARGE_NS / `IBC_CLK_NS)
`define IBC_REF_LEN      ((`IBC_REF_LEN_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_SZ_32K       2'h0
`define IBC_SZ_64K       2'h1
`define IBC_SZ_128K      2'h2
`define IBC_SZ_256K      2'h3
`define IBC_CAP_32K      14
`define IBC_CAP_64K      15
`define IBC_CAP_128K     16
`define IBC_CAP_256K     17
`endif

// [src/ibc_pkg.sv]
// Types shared by the memory board controller.
package ibc_pkg;
    typedef enum logic [1:0] {IF_IDLE, IF_SEL, IF_DATA} ibc_if_e;
    typedef struct packed {
        logic       hit;
        logic [1:0] mod;
        logic       bank;
        logic [6:0] row;
        logic [6:0] col;
    } ibc_req_s;
endpackage
